//--- inc/eipm_pkg.sv
/*
 * Constants, register map and state types for the external interrupt and
 * power mode controller.
 * Assumes an AHB-Lite master with 32-bit single word transfers.
 */
package eipm_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] EIPM_SENS_OFF     = 8'h00;
   localparam logic [7:0] EIPM_PSEL_OFF     = 8'h04;
   localparam logic [7:0] EIPM_CTRL_OFF     = 8'h08;
   localparam logic [7:0] EIPM_STAT_OFF     = 8'h0C;
   localparam logic [7:0] EIPM_CMD_OFF      = 8'h10;

   // ==========================================================
   // Reset values
   localparam logic [7:0] EIPM_SENS_RST     = 8'h00;
   localparam logic [7:0] EIPM_PSEL_RST     = 8'h0C;
   localparam logic [7:0] EIPM_PIN_IDLE     = 8'hFF;

   // ==========================================================
   // Control register bits
   localparam int EIPM_CTRL_SLOW_BIT        = 0;
   localparam int EIPM_CTRL_AH_EN_BIT       = 1;
   localparam int EIPM_CTRL_AWU_BIT         = 2;
   localparam int EIPM_CTRL_WDG_EN_BIT      = 3;
   localparam int EIPM_CTRL_WDGHLT_BIT      = 4;
   localparam int EIPM_CTRL_PLL_BIT         = 5;
   localparam int EIPM_CTRL_LONG_BIT        = 6;

   // Command register bits
   localparam int EIPM_CMD_WAIT_BIT         = 0;
   localparam int EIPM_CMD_HALT_BIT         = 1;
   localparam int EIPM_CMD_SETI_BIT         = 2;
   localparam int EIPM_CMD_CLRI_BIT         = 3;
   localparam int EIPM_CMD_ACK_BIT          = 4;
   localparam int EIPM_CMD_RET_BIT          = 5;

   // ==========================================================
   // Sensitivity codes
   localparam logic [1:0] EIPM_SENS_FALL_LOW = 2'h0;
   localparam logic [1:0] EIPM_SENS_RISE     = 2'h1;
   localparam logic [1:0] EIPM_SENS_FALL     = 2'h2;
   localparam logic [1:0] EIPM_SENS_BOTH     = 2'h3;

   // ==========================================================
   // Timing
   localparam int EIPM_CLK_MHZ       = 10;
   localparam int EIPM_OSC_SHORT_CYC = 256;
   localparam int EIPM_OSC_LONG_CYC  = 4096;
   localparam int EIPM_PLL_START_US  = 2;
   localparam int EIPM_PLL_START_CYC = EIPM_PLL_START_US * EIPM_CLK_MHZ;
   localparam int EIPM_SLOW_DIV      = 32;
   localparam int EIPM_NORM_DIV      = 2;

   // ==========================================================
   // Power modes
   typedef enum logic [2:0] {
      EIPM_RUN       = 3'b000,
      EIPM_WAIT      = 3'b001,
      EIPM_SLOW_WAIT = 3'b010,
      EIPM_HALT      = 3'b011,
      EIPM_STARTUP   = 3'b100,
      EIPM_PLL_WAIT  = 3'b101
   } eipm_mode_e;

endpackage : eipm_pkg

//--- core/eipm_top.sv
/*
 * External interrupt sensitivity, pin routing and power mode sequencing.
 * Assumes port pins are asynchronous and synchronised here; the CPU
 * reports service entry and return through the command register.
 */
`timescale 1ns/100ps

// Summary of operation
// - Sensitivity register holds four 2-bit fields, line 3 at top.
// - Codes: 00 fall+low, 01 rise, 10 fall, 11 both edges.
// - Sensitivity writes take effect only while interrupt mask is set.
// - Sensitivity register resets to zero.
// - Line 3 comes from port B bit 0, 1 or 2.
// - Line 2 comes from port B bit 3, 4, 5 or 6.
// - Port B bit 4 as line 2 cannot wake from HALT.
// - Line 1 comes from port A bit 4 to 7, reset 7.
// - Line 0 comes from port A bit 0 to 3, reset 0.
// - Pin select register is read/write, resets to 0x0C.
// - After reset run mode, clock at oscillator divided by two.
// - Slow select divides oscillator by 32; clear restores normal.
// - Wait entered in slow mode becomes slow-wait with reduced clock.
// - Wait stops CPU clock only; peripherals keep running.
// - Wait clears mask; stays until interrupt or reset.
// - Halt only when active-halt off and auto-wake disabled.
// - Halt wake restarts oscillator and waits 256 or 4096 cycles.
// - Halt forces mask to 0; pending interrupt wakes at once.
// - Halt stops oscillator and all CPU and peripheral clocks.
// - Halt with watchdog enabled may give watchdog reset instead.
// - Entering service sets mask; return restores saved mask.
// - With PLL enabled, clock returns after PLL startup delay.
// - Edge requests latch until service entry clears them.
module eipm_top
   import eipm_pkg::*;
#(
   parameter int OSC_LONG_CYC = EIPM_OSC_LONG_CYC
) (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Port pins
   input  wire logic [7:0]  port_a_i,
   input  wire logic [7:0]  port_b_i,
   // Interrupt and clock controls
   output logic      [3:0]  ext_irq_req_o,
   output logic             irq_mask_o,
   output logic             cpu_clk_en_o,
   output logic             periph_clk_en_o,
   output logic             osc_on_o,
   output logic             wdg_reset_o
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0]  sens;
      logic [7:0]  psel;
      logic [6:0]  ctrl;
      logic        imask;
      logic        imask_saved;
      logic [7:0]  pa_s1;
      logic [7:0]  pa_s2;
      logic [7:0]  pb_s1;
      logic [7:0]  pb_s2;
      logic [3:0]  line_prev;
      logic [3:0]  pend;
      eipm_mode_e  mode;
      logic [12:0] cnt;
      logic [4:0]  div;
      logic        cpu_en;
      logic        per_en;
      logic        osc_on;
      logic        wdg_rst;
      logic        dp_wr;
      logic [7:0]  dp_addr;
      logic [31:0] rdata;
   } eipm_state_s;

   eipm_state_s st_ff;
   eipm_state_s nxt_st;

   // ==========================================================
   // Decoding used for every line
   function automatic logic line_sel(input logic [7:0] pins,
                                     input logic [1:0] base,
                                     input logic [1:0] code);
      logic [2:0] idx;
      idx = {1'b0, base} + {1'b0, code};
      line_sel = pins[idx];
   endfunction : line_sel

   function automatic logic trig(input logic [1:0] mode,
                                 input logic       now,
                                 input logic       prev);
      logic rise;
      logic fall;
      rise = now & ~prev;
      fall = ~now & prev;
      case (mode)
         EIPM_SENS_FALL_LOW: trig = fall | ~now;
         EIPM_SENS_RISE:     trig = rise;
         EIPM_SENS_FALL:     trig = fall;
         default:            trig = rise | fall;
      endcase
   endfunction : trig

   function automatic logic [1:0] sens_of(input logic [7:0] sens,
                                          input int         idx);
      sens_of = sens[2*idx+1 -: 2];
   endfunction : sens_of

   // ==========================================================
   // Routed lines
   logic [3:0] line_now;
   logic [3:0] halt_ok;
   logic [3:0] edge_hit;

   always_comb begin
      line_now[0] = line_sel(st_ff.pa_s2, 2'h0, st_ff.psel[1:0]);
      line_now[1] = line_sel({4'h0, st_ff.pa_s2[7:4]}, 2'h0,
                             st_ff.psel[3:2]);
      line_now[2] = (st_ff.psel[5:4] == 2'h0) ? st_ff.pb_s2[3] :
                    line_sel({4'h0, st_ff.pb_s2[7:4]}, 2'h0,
                             st_ff.psel[5:4] - 2'h1);
      // Code 11 is reserved and treated as bit 0
      line_now[3] = (st_ff.psel[7:6] == 2'h3) ? st_ff.pb_s2[0] :
                    line_sel(st_ff.pb_s2, 2'h0, st_ff.psel[7:6]);
      halt_ok = 4'hF;
      if (st_ff.psel[5:4] == 2'h1) begin
         halt_ok[2] = 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_line
         assign edge_hit[g] = trig(sens_of(st_ff.sens, g),
                                   line_now[g], st_ff.line_prev[g]);
      end
   endgenerate

   // ==========================================================
   // Bus decode
   logic ap_valid;
   logic [3:0] level_act;
   logic [3:0] req;

   assign ap_valid = hsel_i & hready_i & htrans_i[1];

   always_comb begin
      nxt_st = st_ff;
      nxt_st.pa_s1 = port_a_i;
      nxt_st.pa_s2 = st_ff.pa_s1;
      nxt_st.pb_s1 = port_b_i;
      nxt_st.pb_s2 = st_ff.pb_s1;
      nxt_st.line_prev = line_now;
      nxt_st.wdg_rst = 1'b0;

      // Edge requests stay latched until service entry; level mode is live
      for (int i = 0; i < 4; i++) begin
         level_act[i] = (sens_of(st_ff.sens, i) == EIPM_SENS_FALL_LOW)
                        & ~line_now[i];
      end
      req = st_ff.pend | level_act;

      // Bus address phase
      nxt_st.dp_wr = ap_valid & hwrite_i;
      nxt_st.dp_addr = haddr_i[7:0];
      if (ap_valid & ~hwrite_i) begin
         case (haddr_i[7:0])
            EIPM_SENS_OFF: nxt_st.rdata = {24'h0, st_ff.sens};
            EIPM_PSEL_OFF: nxt_st.rdata = {24'h0, st_ff.psel};
            EIPM_CTRL_OFF: nxt_st.rdata = {25'h0, st_ff.ctrl};
            EIPM_STAT_OFF: nxt_st.rdata = {19'h0, req, st_ff.imask,
                                           1'b0, st_ff.mode, st_ff.pend};
            default:       nxt_st.rdata = 32'h0;
         endcase
      end

      // Service entry clears all four latched edge requests first
      if (st_ff.dp_wr && st_ff.dp_addr == EIPM_CMD_OFF
          && hwdata_i[EIPM_CMD_ACK_BIT]) begin
         nxt_st.pend = 4'h0;
         nxt_st.imask_saved = st_ff.imask;
         nxt_st.imask = 1'b1;
      end
      // New edges win over the clear
      for (int i = 0; i < 4; i++) begin
         if (edge_hit[i] && sens_of(st_ff.sens, i) != EIPM_SENS_FALL_LOW)
            nxt_st.pend[i] = 1'b1;
      end

      // Register writes
      if (st_ff.dp_wr) begin
         case (st_ff.dp_addr)
            EIPM_SENS_OFF: begin
               if (st_ff.imask) begin
                  nxt_st.sens = hwdata_i[7:0];
               end
            end
            EIPM_PSEL_OFF: nxt_st.psel = hwdata_i[7:0];
            EIPM_CTRL_OFF: nxt_st.ctrl = hwdata_i[6:0];
            EIPM_CMD_OFF: begin
               if (hwdata_i[EIPM_CMD_SETI_BIT]) nxt_st.imask = 1'b1;
               if (hwdata_i[EIPM_CMD_CLRI_BIT]) nxt_st.imask = 1'b0;
               if (hwdata_i[EIPM_CMD_RET_BIT]) begin
                  nxt_st.imask = st_ff.imask_saved;
               end
               if (hwdata_i[EIPM_CMD_WAIT_BIT]
                   && st_ff.mode == EIPM_RUN) begin
                  nxt_st.imask = 1'b0;
                  nxt_st.mode = st_ff.ctrl[EIPM_CTRL_SLOW_BIT] ?
                                EIPM_SLOW_WAIT : EIPM_WAIT;
               end else if (hwdata_i[EIPM_CMD_HALT_BIT]
                            && st_ff.mode == EIPM_RUN) begin
                  if (st_ff.ctrl[EIPM_CTRL_WDG_EN_BIT]
                      && !st_ff.ctrl[EIPM_CTRL_WDGHLT_BIT]) begin
                     nxt_st.wdg_rst = 1'b1;
                  end else if (!st_ff.ctrl[EIPM_CTRL_AH_EN_BIT]
                               && !st_ff.ctrl[EIPM_CTRL_AWU_BIT]) begin
                     nxt_st.imask = 1'b0;
                     nxt_st.mode = EIPM_HALT;
                  end
               end
            end
            default: ;
         endcase
      end

      // Power mode sequencing
      nxt_st.cnt = st_ff.cnt + 13'h1;
      case (st_ff.mode)
         EIPM_RUN: nxt_st.cnt = 13'h0;
         EIPM_WAIT, EIPM_SLOW_WAIT: begin
            if (|req) nxt_st.mode = EIPM_RUN;
            nxt_st.cnt = 13'h0;
         end
         EIPM_HALT: begin
            nxt_st.cnt = 13'h0;
            // A pending request not blocked by halt_ok leaves at once, even one from before
            if (|(req & halt_ok)) nxt_st.mode = EIPM_STARTUP;
         end
         EIPM_STARTUP: begin
            if (st_ff.cnt == (st_ff.ctrl[EIPM_CTRL_LONG_BIT] ?
                              13'(OSC_LONG_CYC - 1) :
                              13'(EIPM_OSC_SHORT_CYC - 1))) begin
               nxt_st.cnt = 13'h0;
               nxt_st.mode = st_ff.ctrl[EIPM_CTRL_PLL_BIT] ?
                             EIPM_PLL_WAIT : EIPM_RUN;
            end
         end
         EIPM_PLL_WAIT: begin
            if (st_ff.cnt == 13'(EIPM_PLL_START_CYC - 1)) begin
               nxt_st.mode = EIPM_RUN;
            end
         end
         default: nxt_st.mode = EIPM_RUN;
      endcase

      // Clock divider: one enable pulse per divide period
      if (st_ff.div == 5'(((st_ff.ctrl[EIPM_CTRL_SLOW_BIT])
                          ? EIPM_SLOW_DIV : EIPM_NORM_DIV) - 1)
          || st_ff.div >= 5'(EIPM_SLOW_DIV - 1)) begin
         nxt_st.div = 5'h0;
      end else begin
         nxt_st.div = st_ff.div + 5'h1;
      end
      nxt_st.osc_on = (nxt_st.mode != EIPM_HALT);
      nxt_st.per_en = (nxt_st.div == 5'h0) && nxt_st.osc_on
                      && nxt_st.mode != EIPM_STARTUP
                      && nxt_st.mode != EIPM_PLL_WAIT;
      nxt_st.cpu_en = nxt_st.per_en && nxt_st.mode == EIPM_RUN;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
         st_ff.sens <= EIPM_SENS_RST;
         st_ff.psel <= EIPM_PSEL_RST;
         st_ff.imask <= 1'b1;
         st_ff.mode <= EIPM_RUN;
         st_ff.osc_on <= 1'b1;
         // Pins idle high; starting low would show a false edge after reset
         st_ff.pa_s1 <= EIPM_PIN_IDLE;
         st_ff.pa_s2 <= EIPM_PIN_IDLE;
         st_ff.pb_s1 <= EIPM_PIN_IDLE;
         st_ff.pb_s2 <= EIPM_PIN_IDLE;
         st_ff.line_prev <= EIPM_PIN_IDLE[3:0];
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Outputs
   assign hrdata_o = st_ff.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign ext_irq_req_o = st_ff.pend;
   assign irq_mask_o = st_ff.imask;
   assign cpu_clk_en_o = st_ff.cpu_en;
   assign periph_clk_en_o = st_ff.per_en;
   assign osc_on_o = st_ff.osc_on;
   assign wdg_reset_o = st_ff.wdg_rst;

endmodule : eipm_top

//--- test/eipm_asserts.sv
/* Checker for the interrupt and power mode block, bound to its top.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/100ps
module eipm_chk
   import eipm_pkg::*;
#(
   parameter int OSC_LONG_CYC = EIPM_OSC_LONG_CYC
) (
   // Clock and reset
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   // Bus
   input wire logic        hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   // Controls
   input wire logic [3:0]  ext_irq_req_o,
   input wire logic        irq_mask_o,
   input wire logic        cpu_clk_en_o,
   input wire logic        periph_clk_en_o,
   input wire logic        osc_on_o,
   input wire logic        wdg_reset_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // Assertions
   sequence cmd_wr;
      hsel_i && hready_i && htrans_i[1] && hwrite_i
         && haddr_i[7:0] == EIPM_CMD_OFF;
   endsequence
   bus_ready_a: assert property (hreadyout_o && !hresp_o)
      else $error("bus not ready or not okay");
   unmapped_zero_a: assert property (hsel_i && hready_i && htrans_i[1]
      && !hwrite_i && haddr_i[7:0] > 8'h13 |=> hrdata_o == 32'h0)
      else $error("unmapped read not zero");
   halt_clocks_a: assert property (!osc_on_o |->
      !cpu_clk_en_o && !periph_clk_en_o) else $error("clock in halt");
   halt_mask_a: assert property (!osc_on_o |-> !irq_mask_o)
      else $error("mask set in halt");
   cpu_gap_a: assert property (cpu_clk_en_o |=> !cpu_clk_en_o)
      else $error("cpu enable too dense");
   wdg_pulse_a: assert property (wdg_reset_o |=> !wdg_reset_o)
      else $error("watchdog pulse too long");
   wake_delay_a: assert property ($rose(osc_on_o) |->
      !cpu_clk_en_o [*8]) else $error("cpu clock before startup");
   wfi_mask_a: assert property (cmd_wr ##1 hwdata_i[5:0] == 6'h01
      |=> !irq_mask_o) else $error("wait left mask set");
   reset_state_a: assert property ($rose(rst_n_i) |-> irq_mask_o
      && ext_irq_req_o == 4'h0) else $error("bad state after reset");
   // ==========================================================
   // Coverage
   halt_c: cover property ($fell(osc_on_o));
   wdg_c: cover property (wdg_reset_o);
   req_c: cover property ($rose(ext_irq_req_o[0]));
endmodule : eipm_chk
bind eipm_top eipm_chk #(.OSC_LONG_CYC(OSC_LONG_CYC)) u_chk (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
   .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .ext_irq_req_o(ext_irq_req_o), .irq_mask_o(irq_mask_o),
   .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
   .osc_on_o(osc_on_o), .wdg_reset_o(wdg_reset_o));

//--- test/eipm_pins.sv
/* External signal sources on the port pins.
   Assumes the bench sets wanted levels; pins follow after a clock edge. */
`timescale 1ns/100ps
module eipm_pins (
   // Clock
   input  wire logic       mclk_i,
   // Wanted levels
   input  wire logic [7:0] a_lvl_i,
   input  wire logic [7:0] b_lvl_i,
   // Pins
   output logic      [7:0] port_a_o,
   output logic      [7:0] port_b_o
);
   // Idle high, as with pull-ups, so no edge is seen at start
   initial begin
      port_a_o = 8'hFF;
      port_b_o = 8'hFF;
   end
   always @(posedge mclk_i) begin
      port_a_o <= a_lvl_i;
      port_b_o <= b_lvl_i;
   end
endmodule : eipm_pins

//--- test/testbench.sv
/* Self-checking bench for the interrupt and power mode block.
   Assumes a zero-wait AHB-Lite slave and pins driven by eipm_pins. */
`timescale 1ns/100ps
module testbench;
   import eipm_pkg::*;
   localparam int LONG = 16;
   logic        mclk_i, rst_n_i, hsel, hwrite, hrdy, hresp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0]  pa, pb, port_a, port_b;
   logic [3:0]  req;
   logic        mask, cpu_en, per_en, osc, wdg;
   int          checks, mismatches;
   eipm_top #(.OSC_LONG_CYC(LONG)) dut (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
      .hreadyout_o(hrdy), .hresp_o(hresp), .port_a_i(port_a),
      .port_b_i(port_b), .ext_irq_req_o(req), .irq_mask_o(mask),
      .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
      .osc_on_o(osc), .wdg_reset_o(wdg));
   eipm_pins u_pins (.mclk_i(mclk_i), .a_lvl_i(pa), .b_lvl_i(pb),
      .port_a_o(port_a), .port_b_o(port_b));
   // ==========================================================
   // Common tasks
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : cyc
   task automatic rdy();
      int n;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (hrdy !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         finish_test();
      end
   endtask : rdy
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy();
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      chk(d, e);
      chk({31'h0, hresp}, 32'h0);
   endtask : rdchk
   task automatic cmd(input int b);
      wr(EIPM_CMD_OFF, 32'h1 << b);
   endtask : cmd
   task automatic cnt(output int nc, output int np);
      nc = 0;
      np = 0;
      repeat (64) begin
         @(posedge mclk_i);
         nc += cpu_en;
         np += per_en;
      end
   endtask : cnt
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      rdchk(EIPM_SENS_OFF, 32'h00);
      rdchk(EIPM_PSEL_OFF, 32'h0C);
      wr(EIPM_PSEL_OFF, 32'h25);
      rdchk(EIPM_PSEL_OFF, 32'h25);
      wr(8'h40, 32'hFF);
      rdchk(8'h40, 32'h0);
      wr(EIPM_SENS_OFF, 32'hE4);
      rdchk(EIPM_SENS_OFF, 32'hE4);
      cmd(EIPM_CMD_CLRI_BIT);
      wr(EIPM_SENS_OFF, 32'h1B);
      rdchk(EIPM_SENS_OFF, 32'hE4);
      cmd(EIPM_CMD_SETI_BIT);
      $display("test regs done");
   endtask : t_regs
   task automatic t_route();
      logic [1:0] k3;
      for (int j = 0; j < 4; j++) begin
         // Line 3 has only three pins; its last code is left unused
         k3 = (j == 3) ? 2'h0 : 2'(j);
         wr(EIPM_PSEL_OFF, {24'h0, k3, 2'(j), 2'(j), 2'(j)});
         wr(EIPM_SENS_OFF, 32'hAA);
         cmd(EIPM_CMD_ACK_BIT);
         cyc(1);
         chk({28'h0, req}, 32'h0);
         pa <= ~(8'h11 << j);
         pb <= ~((8'h1 << k3) | (8'h8 << j));
         cyc(5);
         chk({28'h0, req}, 32'hF);
         pa <= 8'hFF;
         pb <= 8'hFF;
         cyc(5);
      end
      wr(EIPM_PSEL_OFF, 32'h0C);
      $display("test route done");
   endtask : t_route
   task automatic t_codes();
      logic [31:0] d;
      for (int c = 1; c < 4; c++) begin
         wr(EIPM_SENS_OFF, c);
         pa <= 8'hFE;
         cyc(5);
         cmd(EIPM_CMD_ACK_BIT);
         pa <= 8'hFF;
         cyc(5);
         chk(req[0], c != 2);
         cmd(EIPM_CMD_ACK_BIT);
         pa <= 8'hFE;
         cyc(5);
         chk(req[0], c != 1);
         pa <= 8'hFF;
         cyc(5);
         cmd(EIPM_CMD_ACK_BIT);
      end
      // Code 00 is level: request shows while low, nothing is latched
      wr(EIPM_SENS_OFF, 32'h0);
      pa <= 8'hFE;
      cyc(5);
      bus(1'b0, EIPM_STAT_OFF, 32'h0, d);
      chk({24'h0, d[12:9], d[3:0]}, 32'h10);
      pa <= 8'hFF;
      cyc(5);
      $display("test codes done");
   endtask : t_codes
   task automatic t_clk();
      int nc, np;
      logic [31:0] d;
      cnt(nc, np);
      chk(nc, 64 / EIPM_NORM_DIV);
      wr(EIPM_CTRL_OFF, 32'h1);
      cyc(40);
      cnt(nc, np);
      chk(nc, 64 / EIPM_SLOW_DIV);
      wr(EIPM_SENS_OFF, 32'h02);
      cmd(EIPM_CMD_WAIT_BIT);
      bus(1'b0, EIPM_STAT_OFF, 32'h0, d);
      chk(d[6:4], EIPM_SLOW_WAIT);
      chk(mask, 1'b0);
      cnt(nc, np);
      chk(nc, 32'h0);
      chk(np, 64 / EIPM_SLOW_DIV);
      pa <= 8'hFE;
      cyc(8);
      bus(1'b0, EIPM_STAT_OFF, 32'h0, d);
      chk(d[6:4], EIPM_RUN);
      cmd(EIPM_CMD_ACK_BIT);
      cyc(1);
      chk(mask, 1'b1);
      cmd(EIPM_CMD_RET_BIT);
      cyc(1);
      chk(mask, 1'b0);
      pa <= 8'hFF;
      wr(EIPM_CTRL_OFF, 32'h0);
      $display("test clocks done");
   endtask : t_clk
   task automatic t_halt(input int pll);
      int n, e;
      e = LONG + pll * EIPM_PLL_START_CYC;
      wr(EIPM_CTRL_OFF, (32'h1 << EIPM_CTRL_LONG_BIT) | (pll << 5));
      wr(EIPM_PSEL_OFF, 32'h1C);
      cmd(EIPM_CMD_SETI_BIT);
      wr(EIPM_SENS_OFF, 32'hAA);
      cmd(EIPM_CMD_ACK_BIT);
      cmd(EIPM_CMD_HALT_BIT);
      cyc(3);
      chk({osc, mask}, 2'b00);
      pb <= 8'hEF;
      cyc(8);
      chk(osc, 1'b0);
      pa <= 8'hFE;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (cpu_en !== 1'b1 && n < 300);
      if (n >= 300) begin
         mismatches++;
         finish_test();
      end
      chk(osc, 1'b1);
      chk(n >= e && n <= e + 12, 1'b1);
      pa <= 8'hFF;
      pb <= 8'hFF;
      cyc(5);
      cmd(EIPM_CMD_ACK_BIT);
      wr(EIPM_PSEL_OFF, 32'h0C);
      $display("test halt done");
   endtask : t_halt
   task automatic t_block();
      int seen;
      for (int b = 1; b < 3; b++) begin
         wr(EIPM_CTRL_OFF, 32'h1 << b);
         cmd(EIPM_CMD_HALT_BIT);
         cyc(4);
         chk(osc, 1'b1);
      end
      wr(EIPM_CTRL_OFF, 32'h1 << EIPM_CTRL_WDG_EN_BIT);
      cmd(EIPM_CMD_HALT_BIT);
      seen = 0;
      repeat (8) begin
         @(posedge mclk_i);
         seen |= wdg;
      end
      chk({seen[0], osc}, 2'b11);
      $display("test block done");
   endtask : t_block
   // ==========================================================
   // Clock, reset and main sequence
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   initial begin
      #(100 * 90000);
      mismatches++;
      finish_test();
   end
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      pa = 8'hFF;
      pb = 8'hFF;
      rst_n_i = 1'b0;
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_route();
      t_codes();
      t_clk();
      t_halt(0);
      t_halt(1);
      t_block();
      finish_test();
   end
endmodule : testbench
